//--- design/charger_cfg_regs.v
// Overview of operation
// - fast-charge code in bits 7:2, 512 mA base, 64 mA steps, codes to 100111.
// - fast-charge code resets to 011000 (2048 mA); cold and reduced bits reset zero.
// - charge-current bit 1 picks boost cold threshold, 76% or 79% of rail.
// - reduced bit set gives 20% fast-charge and 50% pre-charge current.
// - pre-charge current from bits 7:4, 128 mA steps on 128 mA base.
// - end-of-charge current from bits 3:0, same scale, resets to 0001.
// - pre-charge/end-of-charge register resets to 00010001.
// - charge voltage from bits 7:2, 16 mV steps above 3.504 V.
// - charge-voltage register resets to 0xB2, giving 4.208 V.
// - charge-voltage bit 1 sets pre-charge exit at 2.8 V or 3.0 V.
// - charge-voltage bit 0 sets recharge offset 100 mV or 300 mV.
// - termination/timer register resets to 10011010.
// - termination enable, watchdog, safety enable, timer select, reserved bit positions.
// - every bit of all four registers is readable and writable.
// - watchdog select 00 off, else 40 s, 80 s, 160 s.
// - safety timer select gives 5, 8, 12 or 20 hours.
// - termination enable bit 1 allows termination; defaults to 1.
`timescale 1ns/1ps
`include "charger_cfg_defs.vh"
module charger_cfg_regs (
    input  wire        clk_in,
    input  wire        resetn_in,
    // register port from the serial bus engine
    input  wire [7:0]  reg_addr_in,
    input  wire        reg_wr_en_in,
    input  wire [7:0]  reg_wr_data_in,
    input  wire        reg_rd_en_in,
    output reg  [7:0]  reg_rd_data_out,
    output reg         reg_rd_valid_out,
    output reg         reg_rd_hit_out,
    // return all four registers to defaults
    input  wire        defaults_reload_in,
    // raw fields
    output wire [5:0]  fast_charge_current_code_out,
    output wire        cold_threshold_select_out,
    output wire        reduced_current_select_out,
    output wire [3:0]  precharge_current_code_out,
    output wire [3:0]  end_of_charge_current_code_out,
    output wire [5:0]  charge_voltage_code_out,
    output wire        precharge_exit_threshold_select_out,
    output wire        recharge_offset_select_out,
    output wire [1:0]  watchdog_select_out,
    output wire [1:0]  fast_charge_timer_select_out,
    // decoded set points for the regulation loops
    output reg  [12:0] fast_charge_ma_out,
    output reg         fast_charge_code_supported_out,
    output reg  [11:0] precharge_ma_out,
    output reg  [11:0] end_of_charge_ma_out,
    output reg  [12:0] charge_voltage_mv_out,
    output reg  [11:0] precharge_exit_mv_out,
    output reg  [8:0]  recharge_offset_mv_out,
    output reg  [9:0]  cold_threshold_permille_out,
    // timer and termination settings
    output wire        termination_enable_out,
    output wire        watchdog_enable_out,
    output wire [7:0]  watchdog_timeout_s_out,
    output wire        safety_timer_enable_out,
    output wire [4:0]  safety_limit_hours_out
);

    // four byte-wide registers
    localparam NUM_REGS = 4;

    // index 0 is the lowest address
    wire [7:0]  reg_value [0:NUM_REGS-1];
    wire [NUM_REGS-1:0] addr_hit;

    // named views of the images
    wire [7:0]  chg_cur_r;
    wire [7:0]  pre_term_r;
    wire [7:0]  chg_volt_r;
    wire [7:0]  term_timer_r;

    // set points ahead of the flops
    reg  [12:0] fast_ma_d;
    reg  [12:0] fast_applied_d;
    reg  [11:0] pre_ma_d;
    reg  [11:0] pre_applied_d;
    reg  [11:0] end_ma_d;
    reg  [12:0] volt_mv_d;
    // read mux output
    reg  [7:0]  rd_data_d;

    // one storage cell per register, each with its own default
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1)
        begin : g_reg
            // cells differ in default and address only
            // charge-current default 0x60
            localparam [7:0] RST =
                (gi == 0) ? `CFG_RST_CHG_CURRENT :
                (gi == 1) ? `CFG_RST_PRE_TERM_CURRENT :
                (gi == 2) ? `CFG_RST_CHG_VOLTAGE :
                            `CFG_RST_TERM_TIMER;
            localparam [7:0] ADDR =
                (gi == 0) ? `CFG_ADDR_CHG_CURRENT :
                (gi == 1) ? `CFG_ADDR_PRE_TERM_CURRENT :
                (gi == 2) ? `CFG_ADDR_CHG_VOLTAGE :
                            `CFG_ADDR_TERM_TIMER;

            // exact address match, no aliasing
            // one hot: gates writes and steers reads
            assign addr_hit[gi] = (reg_addr_in == ADDR);

            // all bits writable
            // only the addressed cell sees the strobe
            cfg_reg_cell #(
                .RESET_VAL (RST)
            ) u_cell (
                .clk_in     (clk_in),
                .resetn_in  (resetn_in),
                .reload_in  (defaults_reload_in),
                .wr_en_in   (reg_wr_en_in & addr_hit[gi]),
                .wr_data_in (reg_wr_data_in),
                .value_out  (reg_value[gi])
            );
        end
    endgenerate

    // fixed order of the four images
    assign chg_cur_r    = reg_value[0];
    assign pre_term_r   = reg_value[1];
    assign chg_volt_r   = reg_value[2];
    assign term_timer_r = reg_value[3];

    assign fast_charge_current_code_out = chg_cur_r[`FAST_CUR_MSB:`FAST_CUR_LSB];

    assign cold_threshold_select_out    = chg_cur_r[`COLD_SEL_BIT];

    assign reduced_current_select_out   = chg_cur_r[`REDUCED_BIT];

    assign precharge_current_code_out   = pre_term_r[`PRE_CUR_MSB:`PRE_CUR_LSB];

    assign end_of_charge_current_code_out = pre_term_r[`END_CUR_MSB:`END_CUR_LSB];

    assign charge_voltage_code_out      = chg_volt_r[`VOLT_MSB:`VOLT_LSB];

    assign precharge_exit_threshold_select_out = chg_volt_r[`EXIT_SEL_BIT];

    assign recharge_offset_select_out   = chg_volt_r[`RECHG_SEL_BIT];

    assign watchdog_select_out          = term_timer_r[`WDOG_MSB:`WDOG_LSB];
    assign fast_charge_timer_select_out = term_timer_r[`SAFETY_SEL_MSB:`SAFETY_SEL_LSB];

    // fast-charge current in mA
    // code 63 gives 4544 mA, fits 13 bits
    always @*
    begin
        fast_ma_d = `FAST_BASE_MA
                  + ({7'h00, chg_cur_r[`FAST_CUR_MSB:`FAST_CUR_LSB]} * `FAST_STEP_MA);
    end

    // same scale for end-of-charge
    // code 15 gives 2048 mA, fits 12 bits
    always @*
    begin
        pre_ma_d = `CUR_BASE_MA
                 + ({8'h00, pre_term_r[`PRE_CUR_MSB:`PRE_CUR_LSB]} * `CUR_STEP_MA);
        end_ma_d = `CUR_BASE_MA
                 + ({8'h00, pre_term_r[`END_CUR_MSB:`END_CUR_LSB]} * `CUR_STEP_MA);
    end

    // reduced mode scales both charge currents
    // divide by a constant; truncates toward zero, worst error under 1 mA
    // both currents follow the bit together
    always @*
    begin
        if (chg_cur_r[`REDUCED_BIT])
        begin
            fast_applied_d = fast_ma_d / `REDUCED_FAST_DIV;
            pre_applied_d  = {1'b0, pre_ma_d[11:1]};
        end
        else
        begin
            fast_applied_d = fast_ma_d;
            pre_applied_d  = pre_ma_d;
        end
    end

    // regulation voltage in mV
    // code 63 gives 4512 mV, fits 13 bits
    always @*
    begin
        volt_mv_d = `VOLT_BASE_MV
                  + ({7'h00, chg_volt_r[`VOLT_MSB:`VOLT_LSB]} * `VOLT_STEP_MV);
    end

    // set points go out through flops so the analog side never sees glitches
    // they trail the register by one edge
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            // zeros keep the loops idle in reset
            fast_charge_ma_out             <= 13'h0000;
            fast_charge_code_supported_out <= 1'b0;
            precharge_ma_out               <= 12'h000;
            end_of_charge_ma_out           <= 12'h000;
            charge_voltage_mv_out          <= 13'h0000;
            precharge_exit_mv_out          <= 12'h000;
            recharge_offset_mv_out         <= 9'h000;
            cold_threshold_permille_out    <= 10'h000;
        end
        else
        begin
            fast_charge_ma_out   <= fast_applied_d;
            precharge_ma_out     <= pre_applied_d;
            end_of_charge_ma_out <= end_ma_d;

            // codes above 100111 flagged unsupported
            // the code is kept so read-back matches
            fast_charge_code_supported_out <=
                (chg_cur_r[`FAST_CUR_MSB:`FAST_CUR_LSB] <= `FAST_MAX_CODE);

            // voltage set point; codes above 4.400 V stored, not clamped
            charge_voltage_mv_out <= volt_mv_d;

            precharge_exit_mv_out <= chg_volt_r[`EXIT_SEL_BIT] ? `EXIT_HI_MV : `EXIT_LO_MV;

            recharge_offset_mv_out <= chg_volt_r[`RECHG_SEL_BIT] ? `RECHG_HI_MV : `RECHG_LO_MV;

            cold_threshold_permille_out <=
                chg_cur_r[`COLD_SEL_BIT] ? `COLD_HI_PERMILLE : `COLD_LO_PERMILLE;
        end
    end

    // termination enable, watchdog and safety timer decode
    // same one-edge lag as the set points,
    // so the set-point and timer outputs move together; the raw field outputs follow the register at once
    timer_select_decode u_timer_dec (
        .clk_in                  (clk_in),
        .resetn_in               (resetn_in),
        .term_timer_in           (term_timer_r),
        .termination_enable_out  (termination_enable_out),
        .watchdog_enable_out     (watchdog_enable_out),
        .watchdog_timeout_s_out  (watchdog_timeout_s_out),
        .safety_timer_enable_out (safety_timer_enable_out),
        .safety_limit_hours_out  (safety_limit_hours_out)
    );

    // reserved bits read back whatever the host left there
    // a miss reads zero, so it is harmless
    always @*
    begin
        case (addr_hit)
            4'b0001: rd_data_d = chg_cur_r;
            4'b0010: rd_data_d = pre_term_r;
            4'b0100: rd_data_d = chg_volt_r;
            4'b1000: rd_data_d = term_timer_r;
            default: rd_data_d = 8'h00;
        endcase
    end

    // read data registered; a write in the same cycle is seen on the next read
    // valid pulses; data and hit hold
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            reg_rd_data_out  <= 8'h00;
            reg_rd_valid_out <= 1'b0;
            reg_rd_hit_out   <= 1'b0;
        end
        else
        begin
            reg_rd_valid_out <= reg_rd_en_in;

            // misses answer too, hit low
            if (reg_rd_en_in)
            begin
                reg_rd_data_out <= rd_data_d;
                reg_rd_hit_out  <= |addr_hit;
            end
        end
    end

endmodule

//--- design/charger_cfg_defs.vh
`ifndef CHARGER_CFG_DEFS_VH
`define CHARGER_CFG_DEFS_VH

// register addresses on the internal register port
`define CFG_ADDR_CHG_CURRENT      8'h02
`define CFG_ADDR_PRE_TERM_CURRENT 8'h03
`define CFG_ADDR_CHG_VOLTAGE      8'h04
`define CFG_ADDR_TERM_TIMER       8'h05

// reset values
`define CFG_RST_CHG_CURRENT       8'h60
`define CFG_RST_PRE_TERM_CURRENT  8'h11
`define CFG_RST_CHG_VOLTAGE       8'hB2
`define CFG_RST_TERM_TIMER        8'h9A

// charge current register fields
`define FAST_CUR_MSB              7
`define FAST_CUR_LSB              2
`define COLD_SEL_BIT              1
`define REDUCED_BIT               0

// pre-charge / end-of-charge current register fields
`define PRE_CUR_MSB               7
`define PRE_CUR_LSB               4
`define END_CUR_MSB               3
`define END_CUR_LSB               0

// charge voltage register fields
`define VOLT_MSB                  7
`define VOLT_LSB                  2
`define EXIT_SEL_BIT              1
`define RECHG_SEL_BIT             0

// termination / timer register fields
`define TERM_EN_BIT               7
`define TT_RSVD_HI_BIT            6
`define WDOG_MSB                  5
`define WDOG_LSB                  4
`define SAFETY_EN_BIT             3
`define SAFETY_SEL_MSB            2
`define SAFETY_SEL_LSB            1
`define TT_RSVD_LO_BIT            0

// current scales in mA (512, 64, 3008 max code 39, 128, 128)
`define FAST_BASE_MA              13'h0200
`define FAST_STEP_MA              13'h0040
`define FAST_MAX_CODE             6'h27
`define CUR_BASE_MA               12'h080
`define CUR_STEP_MA               12'h080
`define REDUCED_FAST_DIV          13'h0005

// voltage scales in mV (3504, 16, 2800, 3000, 100, 300)
`define VOLT_BASE_MV              13'h0DB0
`define VOLT_STEP_MV              13'h0010
`define EXIT_LO_MV                12'hAF0
`define EXIT_HI_MV                12'hBB8
`define RECHG_LO_MV               9'h064
`define RECHG_HI_MV               9'h12C

// cold threshold in permille of the regulator rail (760, 790)
`define COLD_LO_PERMILLE          10'h2F8
`define COLD_HI_PERMILLE          10'h316

// watchdog timeout in seconds (40, 80, 160)
`define WDOG_40_S                 8'h28
`define WDOG_80_S                 8'h50
`define WDOG_160_S                8'hA0

// fast-charge safety limit in hours (5, 8, 12, 20)
`define SAFETY_5_H                5'h05
`define SAFETY_8_H                5'h08
`define SAFETY_12_H               5'h0C
`define SAFETY_20_H               5'h14

`endif

//--- design/cfg_reg_cell.v
`timescale 1ns/1ps
module cfg_reg_cell #(
    parameter [7:0] RESET_VAL = 8'h00
) (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire       reload_in,
    input  wire       wr_en_in,
    input  wire [7:0] wr_data_in,
    output wire [7:0] value_out
);

    reg  [7:0] value_q;
    reg  [7:0] value_d;

    // reload to defaults beats a write in the same cycle
    always @*
    begin
        value_d = value_q;
        if (reload_in)
            value_d = RESET_VAL;
        else if (wr_en_in)
            value_d = wr_data_in;
    end

    // every bit, reserved ones too, is stored as written
    always @(posedge clk_in)
    begin
        if (!resetn_in)
            value_q <= RESET_VAL;
        else
            value_q <= value_d;
    end

    assign value_out = value_q;

endmodule

//--- design/timer_select_decode.v
`timescale 1ns/1ps
`include "charger_cfg_defs.vh"
module timer_select_decode (
    input  wire       clk_in,
    input  wire       resetn_in,
    input  wire [7:0] term_timer_in,
    output reg        termination_enable_out,
    output reg        watchdog_enable_out,
    output reg  [7:0] watchdog_timeout_s_out,
    output reg        safety_timer_enable_out,
    output reg  [4:0] safety_limit_hours_out
);

    reg  [7:0] wdog_s_d;
    reg  [4:0] safety_h_d;

    // watchdog select: 00 turns the timer off
    always @*
    begin
        case (term_timer_in[`WDOG_MSB:`WDOG_LSB])
            2'b01:   wdog_s_d = `WDOG_40_S;
            2'b10:   wdog_s_d = `WDOG_80_S;
            2'b11:   wdog_s_d = `WDOG_160_S;
            default: wdog_s_d = 8'h00;
        endcase
    end

    // fast-charge safety limit
    always @*
    begin
        case (term_timer_in[`SAFETY_SEL_MSB:`SAFETY_SEL_LSB])
            2'b00:   safety_h_d = `SAFETY_5_H;
            2'b01:   safety_h_d = `SAFETY_8_H;
            2'b10:   safety_h_d = `SAFETY_12_H;
            default: safety_h_d = `SAFETY_20_H;
        endcase
    end

    // outputs lag the register by one cycle; zero during reset
    always @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            termination_enable_out  <= 1'b0;
            watchdog_enable_out     <= 1'b0;
            watchdog_timeout_s_out  <= 8'h00;
            safety_timer_enable_out <= 1'b0;
            safety_limit_hours_out  <= 5'h00;
        end
        else
        begin
            termination_enable_out  <= term_timer_in[`TERM_EN_BIT];
            watchdog_enable_out     <= |term_timer_in[`WDOG_MSB:`WDOG_LSB];
            watchdog_timeout_s_out  <= wdog_s_d;
            safety_timer_enable_out <= term_timer_in[`SAFETY_EN_BIT];
            safety_limit_hours_out  <= safety_h_d;
        end
    end

endmodule

//--- bench/charger_cfg_regs_properties.sv
`timescale 1ns/1ps
// decoded outputs lag their register fields by one edge, so they are tied to $past of the fields
module charger_cfg_regs_properties (
    input wire        clk_in,
    input wire        resetn_in,
    input wire        reg_rd_en_in,
    input wire        reg_rd_valid_out,
    input wire        defaults_reload_in,
    input wire [5:0]  fast_charge_current_code_out,
    input wire        cold_threshold_select_out,
    input wire        reduced_current_select_out,
    input wire [3:0]  precharge_current_code_out,
    input wire [3:0]  end_of_charge_current_code_out,
    input wire [5:0]  charge_voltage_code_out,
    input wire        precharge_exit_threshold_select_out,
    input wire        recharge_offset_select_out,
    input wire [12:0] fast_charge_ma_out,
    input wire [11:0] precharge_ma_out,
    input wire [11:0] end_of_charge_ma_out,
    input wire [12:0] charge_voltage_mv_out,
    input wire [11:0] precharge_exit_mv_out,
    input wire [8:0]  recharge_offset_mv_out,
    input wire [9:0]  cold_threshold_permille_out
);
    // full-scale values before any reduction
    wire [12:0] fast_full = 13'h0200 + 13'h0040 * fast_charge_current_code_out;
    wire [11:0] pre_full  = 12'h080 + 12'h080 * precharge_current_code_out;
    wire [11:0] end_full  = 12'h080 + 12'h080 * end_of_charge_current_code_out;
    wire [12:0] volt_full = 13'h0DB0 + 13'h0010 * charge_voltage_code_out;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_rd_valid_next:
    assert property (reg_rd_en_in |=> reg_rd_valid_out) else $error("read not answered next cycle");
    a_reload_fields:
    assert property (defaults_reload_in |=> fast_charge_current_code_out == 6'h18
        && end_of_charge_current_code_out == 4'h1 && charge_voltage_code_out == 6'h2C)
        else $error("reload did not restore fields");
    a_fast_decode:
    assert property ($past(resetn_in) |-> fast_charge_ma_out == ($past(reduced_current_select_out)
        ? $past(fast_full) / 13'h0005 : $past(fast_full))) else $error("fast current mismatch");
    a_pre_decode:
    assert property ($past(resetn_in) |-> precharge_ma_out == ($past(reduced_current_select_out)
        ? $past(pre_full) >> 1 : $past(pre_full))) else $error("pre-charge current mismatch");
    a_end_decode:
    assert property ($past(resetn_in) |-> end_of_charge_ma_out == $past(end_full))
        else $error("end-of-charge current mismatch");
    a_volt_decode:
    assert property ($past(resetn_in) |-> charge_voltage_mv_out == $past(volt_full))
        else $error("charge voltage mismatch");
    a_exit_select:
    assert property ($past(resetn_in) |-> precharge_exit_mv_out
        == ($past(precharge_exit_threshold_select_out) ? 12'hBB8 : 12'hAF0)) else $error("exit mismatch");
    a_rechg_select:
    assert property ($past(resetn_in) |-> recharge_offset_mv_out
        == ($past(recharge_offset_select_out) ? 9'h12C : 9'h064)) else $error("recharge mismatch");
    a_cold_select:
    assert property ($past(resetn_in) |-> cold_threshold_permille_out
        == ($past(cold_threshold_select_out) ? 10'h316 : 10'h2F8)) else $error("cold mismatch");

    c_reduced: cover property (reduced_current_select_out ##1 reduced_current_select_out);
    c_read: cover property (reg_rd_en_in ##1 reg_rd_valid_out);
    c_reload: cover property (defaults_reload_in);
endmodule

bind charger_cfg_regs charger_cfg_regs_properties charger_cfg_regs_properties_i (
    .clk_in, .resetn_in, .reg_rd_en_in, .reg_rd_valid_out, .defaults_reload_in,
    .fast_charge_current_code_out, .cold_threshold_select_out, .reduced_current_select_out,
    .precharge_current_code_out, .end_of_charge_current_code_out, .charge_voltage_code_out,
    .precharge_exit_threshold_select_out, .recharge_offset_select_out, .fast_charge_ma_out,
    .precharge_ma_out, .end_of_charge_ma_out, .charge_voltage_mv_out, .precharge_exit_mv_out,
    .recharge_offset_mv_out, .cold_threshold_permille_out);

//--- bench/cfg_host_model.sv
`timescale 1ns/1ps
// host side of the register port; idle address and data are inverted so stale values never help
module cfg_host_model (
    input  wire       clk_in,
    input  wire [7:0] reg_rd_data_out,
    input  wire       reg_rd_valid_out,
    input  wire       reg_rd_hit_out,
    output reg  [7:0] reg_addr_in,
    output reg        reg_wr_en_in,
    output reg  [7:0] reg_wr_data_in,
    output reg        reg_rd_en_in,
    output reg        defaults_reload_in
);
    reg rsvd_ok;

    // quiet bus at time zero
    initial
    begin
        {reg_addr_in, reg_wr_en_in, reg_wr_data_in, reg_rd_en_in, defaults_reload_in} = 19'h0_0000;
        rsvd_ok = 1'b0;
    end

    // one-cycle write strobe
    task write_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            #1;
            reg_addr_in = a;
            reg_wr_data_in = (a == 8'h05 && !rsvd_ok) ? (d & 8'hBE) : d;
            reg_wr_en_in = 1'b1;
            @(posedge clk_in);
            #1;
            reg_wr_en_in = 1'b0;
            reg_addr_in = ~a;
            reg_wr_data_in = ~reg_wr_data_in;
        end
    endtask

    // read answer arrives in the cycle after the strobe is taken
    task read_reg(input [7:0] a, output [7:0] d, output h, output v);
        begin
            @(posedge clk_in);
            #1;
            reg_addr_in = a;
            reg_rd_en_in = 1'b1;
            @(posedge clk_in);
            #1;
            reg_rd_en_in = 1'b0;
            reg_addr_in = ~a;
            d = reg_rd_data_out;
            h = reg_rd_hit_out;
            v = reg_rd_valid_out;
        end
    endtask

    task reload_pulse;
        begin
            @(posedge clk_in);
            #1;
            defaults_reload_in = 1'b1;
            @(posedge clk_in);
            #1;
            defaults_reload_in = 1'b0;
        end
    endtask
endmodule

//--- bench/charger_cfg_regs_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared = n_compared + 1; if ((got) !== (exp)) begin error_cnt = error_cnt + 1; \
    $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp); end end
module charger_cfg_regs_bench;
    reg         clk_in;
    reg         resetn_in;
    integer     error_cnt;
    integer     n_compared;
    integer     i;
    reg  [7:0]  rd_d;
    reg         rd_h;
    reg         rd_v;
    reg  [7:0]  rst_v [0:3];
    reg  [7:0]  pat [0:3];
    reg  [7:0]  wd_s [0:3];
    reg  [4:0]  hrs [0:3];
    wire [7:0]  reg_addr_in, reg_wr_data_in, reg_rd_data_out, watchdog_timeout_s_out;
    wire        reg_wr_en_in, reg_rd_en_in, reg_rd_valid_out, reg_rd_hit_out, defaults_reload_in;
    wire [5:0]  fast_charge_current_code_out, charge_voltage_code_out;
    wire [3:0]  end_of_charge_current_code_out, precharge_current_code_out;
    wire [12:0] fast_charge_ma_out, charge_voltage_mv_out;
    wire [11:0] precharge_ma_out, precharge_exit_mv_out, end_of_charge_ma_out;
    wire [1:0]  watchdog_select_out, fast_charge_timer_select_out;
    wire        cold_threshold_select_out, reduced_current_select_out;
    wire        precharge_exit_threshold_select_out, recharge_offset_select_out;
    wire [8:0]  recharge_offset_mv_out;
    wire [9:0]  cold_threshold_permille_out;
    wire [4:0]  safety_limit_hours_out;
    wire        termination_enable_out, watchdog_enable_out, safety_timer_enable_out;
    wire        fast_charge_code_supported_out;

    charger_cfg_regs charger_cfg_regs_i (.clk_in, .resetn_in, .reg_addr_in, .reg_wr_en_in,
        .reg_wr_data_in, .reg_rd_en_in, .reg_rd_data_out, .reg_rd_valid_out, .reg_rd_hit_out,
        .defaults_reload_in, .fast_charge_current_code_out, .cold_threshold_select_out,
        .reduced_current_select_out, .precharge_current_code_out, .end_of_charge_current_code_out,
        .charge_voltage_code_out, .precharge_exit_threshold_select_out, .recharge_offset_select_out,
        .watchdog_select_out, .fast_charge_timer_select_out, .fast_charge_ma_out,
        .fast_charge_code_supported_out, .precharge_ma_out, .end_of_charge_ma_out, .charge_voltage_mv_out,
        .precharge_exit_mv_out, .recharge_offset_mv_out, .cold_threshold_permille_out,
        .termination_enable_out, .watchdog_enable_out, .watchdog_timeout_s_out,
        .safety_timer_enable_out, .safety_limit_hours_out);

    cfg_host_model cfg_host_model_i (.clk_in, .reg_rd_data_out, .reg_rd_valid_out, .reg_rd_hit_out,
        .reg_addr_in, .reg_wr_en_in, .reg_wr_data_in, .reg_rd_en_in, .defaults_reload_in);

    // 125 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // the sequence needs well under a thousand cycles
    initial
    begin
        #40000;
        error_cnt = error_cnt + 1;
        finish_test;
    end

    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // decoded outputs follow the registers one edge later
    task settle;
        begin
            @(posedge clk_in);
            #1;
        end
    endtask

    task check_defaults;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                cfg_host_model_i.read_reg(8'h02 + i[7:0], rd_d, rd_h, rd_v);
                `CHK({rd_v, rd_h, rd_d}, {2'b11, rst_v[i]})
            end
            `CHK({fast_charge_current_code_out, end_of_charge_current_code_out}, 10'h181)
            `CHK(end_of_charge_ma_out, 12'h100)
            `CHK({termination_enable_out, fast_charge_ma_out, charge_voltage_mv_out}, {1'b1, 26'h100_1070})
            `CHK({cold_threshold_select_out, reduced_current_select_out, precharge_current_code_out,
                charge_voltage_code_out, precharge_exit_threshold_select_out, recharge_offset_select_out}, 14'h01B2)
        end
    endtask

    // main sequence
    initial
    begin
        error_cnt = 0;
        n_compared = 0;
        resetn_in = 1'b0;
        {rst_v[0], rst_v[1], rst_v[2], rst_v[3]} = 32'h6011_B29A;
        {pat[0], pat[1], pat[2], pat[3]} = 32'hA55A_C3FF;
        {wd_s[0], wd_s[1], wd_s[2], wd_s[3]} = 32'h0028_50A0;
        {hrs[0], hrs[1], hrs[2], hrs[3]} = {5'h05, 5'h08, 5'h0C, 5'h14};
        repeat (4) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        check_defaults;
        $display("test reset values done");

        // every bit, reserved ones too, reads back as written
        cfg_host_model_i.rsvd_ok = 1'b1;
        for (i = 0; i < 4; i = i + 1)
            cfg_host_model_i.write_reg(8'h02 + i[7:0], pat[i]);
        for (i = 0; i < 4; i = i + 1)
        begin
            cfg_host_model_i.read_reg(8'h02 + i[7:0], rd_d, rd_h, rd_v);
            `CHK(rd_d, pat[i])
        end
        `CHK({fast_charge_code_supported_out, fast_charge_ma_out}, {1'b0, 13'h0273})
        `CHK({precharge_ma_out, end_of_charge_ma_out}, 24'h180_580)
        `CHK({charge_voltage_mv_out, precharge_exit_mv_out, recharge_offset_mv_out}, 34'h2_1617_712C)
        `CHK(cold_threshold_permille_out, 10'h2F8)
        $display("test write readback done");

        // top supported code, cold select high, reduction off
        cfg_host_model_i.write_reg(8'h02, 8'h9E);
        settle;
        `CHK({fast_charge_code_supported_out, fast_charge_ma_out}, {1'b1, 13'h0BC0})
        `CHK({cold_threshold_permille_out, precharge_ma_out}, 22'h31_6300)
        cfg_host_model_i.write_reg(8'h02, 8'hA2);
        settle;
        `CHK(fast_charge_code_supported_out, 1'b0)
        cfg_host_model_i.write_reg(8'h06, 8'h00);
        cfg_host_model_i.read_reg(8'h06, rd_d, rd_h, rd_v);
        `CHK({rd_v, rd_h, rd_d}, 10'h200)
        cfg_host_model_i.read_reg(8'h02, rd_d, rd_h, rd_v);
        `CHK(rd_d, 8'hA2)
        $display("test current codes done");

        // every watchdog and safety timer code, termination off
        cfg_host_model_i.rsvd_ok = 1'b0;
        for (i = 0; i < 4; i = i + 1)
        begin
            cfg_host_model_i.write_reg(8'h05, {2'b01, i[1:0], 1'b0, i[1:0], 1'b1});
            settle;
            `CHK({termination_enable_out, watchdog_enable_out, watchdog_timeout_s_out}, {1'b0, i != 0, wd_s[i]})
            `CHK({safety_timer_enable_out, safety_limit_hours_out}, {1'b0, hrs[i]})
            `CHK({watchdog_select_out, fast_charge_timer_select_out}, {i[1:0], i[1:0]})
        end
        $display("test timer codes done");

        // reload, then a reset in mid-run, each restores defaults
        cfg_host_model_i.reload_pulse;
        settle;
        check_defaults;
        cfg_host_model_i.write_reg(8'h03, 8'hFF);
        @(posedge clk_in);
        #1;
        resetn_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        resetn_in = 1'b1;
        settle;
        check_defaults;
        $display("test reload and reset done");
        finish_test;
    end
endmodule
